// ### logic/ir_cfg_pkg.sv
// constants, types and field layout for the infrared carrier configuration block
//
// Behaviour
// - bank decodes indices 0..7; index 5 reserved, others as listed registers.
// - consumer carriers: 30..56 kHz in 1 kHz steps, 56.9 kHz, or 400/450/480 kHz.
// - receive and transmit keep independent band selections.
// - mode-select outputs forced low when driven, auto config on, UART mode.
// - demodulator control resets to 29h.
// - demodulator disabled means demodulator control contents are ignored.
// - five-bit centre field picks receive centre; receive band bit picks set.
// - three-bit bandwidth field sets accepted window; outside carriers are rejected.
// - shared-IR receive ignores centre field, window from bandwidth only.
// - low band receive accepts carriers inside centre/bandwidth window.
// - high band receive supports centre codes 00011, 01000, 01011 only.
// - shared-IR transmit carrier fixed 500 kHz; only pulse width applies.
// - modulator control resets to 69h.
// - transmit frequency from low five bits, pulse width from upper three.
// - low band code 3 is 30 kHz plus 1 kHz/step; high 400/450/480.
// - widths 6/7/9/10.6 us low band, 0.7/0.8/0.9 us high band.
// - remote config bit 5 selects receive band, 0 low, 1 high.
package ir_cfg_pkg;
  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_KHZ       = 1_000_000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_RX_DEMOD = 3'h0;
  localparam logic [2:0] IDX_TX_CARR  = 3'h1;
  localparam logic [2:0] IDX_RC_CFG   = 3'h2;
  localparam logic [2:0] IDX_LINK_BSR = 3'h3;
  localparam logic [2:0] IDX_XCFG1    = 3'h4;
  localparam logic [2:0] IDX_RSVD     = 3'h5;
  localparam logic [2:0] IDX_XCFG3    = 3'h6;
  localparam logic [2:0] IDX_XCFG4    = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RX_DEMOD = 8'h29;
  localparam logic [7:0] RST_TX_CARR  = 8'h69;
  localparam logic [7:0] RST_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_HIGH_BAND_BIT = 2;
  localparam int DEMOD_DIS_BIT    = 4;
  localparam int RX_HIGH_BAND_BIT = 5;
  localparam int AUTO_CFG_BIT     = 7;

  // ----------------------------------------------------------------
  // carrier figures
  // ----------------------------------------------------------------
  localparam int SIR_KHZ       = 500;
  localparam int HI_A_KHZ      = 400;
  localparam int HI_B_KHZ      = 450;
  localparam int HI_C_KHZ      = 480;
  localparam int LOW_STEP_BASE = 27;
  localparam int LOW_TOP_DKHZ  = 569;
  localparam logic [4:0] CODE_HI_A  = 5'h03;
  localparam logic [4:0] CODE_HI_B  = 5'h08;
  localparam logic [4:0] CODE_HI_C  = 5'h0b;
  localparam logic [4:0] CODE_LO_MAX = 5'h1d;
  localparam logic [4:0] CODE_LO_TOP = 5'h1e;
  localparam int PW_6US_NS   = 6000;
  localparam int PW_7US_NS   = 7000;
  localparam int PW_9US_NS   = 9000;
  localparam int PW_10US6_NS = 10600;
  localparam int PW_0US7_NS  = 700;
  localparam int PW_0US8_NS  = 800;
  localparam int PW_0US9_NS  = 900;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe;
  } xcvr_sel_t;

  typedef struct packed {
    logic uart_mode;
    logic sir_mode;
  } link_mode_t;
endpackage

// ### logic/ir_carrier_cfg.sv
// infrared carrier configuration bank with modulator, demodulator window and axi4-lite slave
`timescale 1ns/1ns
module ir_carrier_cfg #(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]     s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [ADDR_W-1:0]     s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  // mode from the uart datapath
  input  wire ir_cfg_pkg::link_mode_t mode,
  input  wire logic                  tx_active,
  // transceiver pins
  input  wire logic                  rx_subcarrier,
  input  wire logic [2:0]            xcvr_id_in,
  output ir_cfg_pkg::xcvr_sel_t      transceiver_mode_sel_out,
  output logic                       tx_carrier,
  output logic                       rx_envelope,
  output logic                       rx_carrier_hit
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // carrier period in clock cycles, zero for a reserved code
  function automatic logic [15:0] period_of(input logic [4:0] code, input logic high);
    logic [16:0] num;
    num = 17'(ir_cfg_pkg::CLK_KHZ);
    period_of = 16'h0000;
    if (high) begin
      unique case (code)
        ir_cfg_pkg::CODE_HI_A: period_of = 16'(ir_cfg_pkg::CLK_KHZ / ir_cfg_pkg::HI_A_KHZ);
        ir_cfg_pkg::CODE_HI_B: period_of = 16'(ir_cfg_pkg::CLK_KHZ / ir_cfg_pkg::HI_B_KHZ);
        ir_cfg_pkg::CODE_HI_C: period_of = 16'(ir_cfg_pkg::CLK_KHZ / ir_cfg_pkg::HI_C_KHZ);
        default:               period_of = 16'h0000;
      endcase
    end else if (code == ir_cfg_pkg::CODE_LO_TOP) begin
      period_of = 16'(ir_cfg_pkg::CLK_KHZ * 10 / ir_cfg_pkg::LOW_TOP_DKHZ);
    end else if (code >= ir_cfg_pkg::CODE_HI_A && code <= ir_cfg_pkg::CODE_LO_MAX) begin
      period_of = 16'(num / (17'(code) + 17'(ir_cfg_pkg::LOW_STEP_BASE)));
    end
  endfunction

  // pulse width in cycles, zero for a reserved code
  function automatic logic [15:0] width_of(input logic [2:0] code, input logic high);
    width_of = 16'h0000;
    unique case ({high, code})
      4'h2:    width_of = 16'(ir_cfg_pkg::PW_6US_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'h3:    width_of = 16'(ir_cfg_pkg::PW_7US_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'h4:    width_of = 16'(ir_cfg_pkg::PW_9US_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'h5:    width_of = 16'(ir_cfg_pkg::PW_10US6_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'ha:    width_of = 16'(ir_cfg_pkg::PW_0US7_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'hb:    width_of = 16'(ir_cfg_pkg::PW_0US8_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      4'hc:    width_of = 16'(ir_cfg_pkg::PW_0US9_NS / ir_cfg_pkg::CLK_PERIOD_NS);
      default: width_of = 16'h0000;
    endcase
  endfunction

  // window bounds as period ratio in 1/256, {low, high}; zero for reserved
  function automatic logic [17:0] bw_ratio(input logic [2:0] code);
    unique case (code)
      3'h1:    bw_ratio = {9'd240, 9'd267};
      3'h2:    bw_ratio = {9'd227, 9'd280};
      3'h3:    bw_ratio = {9'd213, 9'd293};
      3'h4:    bw_ratio = {9'd200, 9'd307};
      3'h5:    bw_ratio = {9'd187, 9'd320};
      3'h6:    bw_ratio = {9'd173, 9'd333};
      default: bw_ratio = 18'h0_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]        rx_demod_window_ctrl_r;
  logic [7:0]        tx_carrier_ctrl_r;
  logic [7:0]        remote_ctl_config_r;
  logic [7:0]        link_ctrl_bank_select_r;
  logic [7:0]        transceiver_config_one_r;
  logic [7:0]        transceiver_config_three_r;
  logic [7:0]        transceiver_config_four_r;
  logic [2:0]        id_s1_r;
  logic [2:0]        id_s2_r;
  logic [2:0]        id_s3_r;
  logic [2:0]        id_f_r;

  logic              aw_have_r;
  logic              w_have_r;
  logic [2:0]        aw_idx_r;
  logic              aw_bad_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              do_write;
  logic [ADDR_W-1:0] ar_addr;

  assign do_write = aw_have_r && w_have_r && !s_bvalid;
  assign ar_addr  = s_araddr;

  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_idx_r  <= 3'h0;
      aw_bad_r  <= 1'b0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        s_awready <= 1'b0;
        aw_idx_r  <= s_awaddr[4:2];
        aw_bad_r  <= (s_awaddr[ADDR_W-1:5] != '0) || (s_awaddr[1:0] != 2'h0);
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        s_wready <= 1'b0;
        wbyte_r  <= s_wdata[7:0];
        wlane_r  <= s_wstrb[0];
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= aw_bad_r ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_demod_window_ctrl_r     <= ir_cfg_pkg::RST_RX_DEMOD;
      tx_carrier_ctrl_r          <= ir_cfg_pkg::RST_TX_CARR;
      remote_ctl_config_r        <= ir_cfg_pkg::RST_ZERO;
      link_ctrl_bank_select_r    <= ir_cfg_pkg::RST_ZERO;
      transceiver_config_one_r   <= ir_cfg_pkg::RST_ZERO;
      transceiver_config_three_r <= ir_cfg_pkg::RST_ZERO;
      transceiver_config_four_r  <= ir_cfg_pkg::RST_ZERO;
    end else if (do_write && wlane_r && !aw_bad_r) begin
      unique case (aw_idx_r)
        ir_cfg_pkg::IDX_RX_DEMOD: rx_demod_window_ctrl_r   <= wbyte_r;
        ir_cfg_pkg::IDX_TX_CARR:  tx_carrier_ctrl_r        <= wbyte_r;
        ir_cfg_pkg::IDX_RC_CFG:   remote_ctl_config_r      <= wbyte_r;
        ir_cfg_pkg::IDX_LINK_BSR: link_ctrl_bank_select_r  <= wbyte_r;
        // bits whose pin is an input keep their value; writes there are ignored
        ir_cfg_pkg::IDX_XCFG1: transceiver_config_one_r <=
          (wbyte_r & {5'h1f, transceiver_config_four_r[2:0]})
          | (transceiver_config_one_r & {5'h00, ~transceiver_config_four_r[2:0]});
        ir_cfg_pkg::IDX_RSVD:     ;
        ir_cfg_pkg::IDX_XCFG3:    transceiver_config_three_r <= wbyte_r;
        ir_cfg_pkg::IDX_XCFG4:    transceiver_config_four_r  <= wbyte_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    unique case (ar_addr[4:2])
      ir_cfg_pkg::IDX_RX_DEMOD: rd_byte = rx_demod_window_ctrl_r;
      ir_cfg_pkg::IDX_TX_CARR:  rd_byte = tx_carrier_ctrl_r;
      ir_cfg_pkg::IDX_RC_CFG:   rd_byte = remote_ctl_config_r;
      ir_cfg_pkg::IDX_LINK_BSR: rd_byte = link_ctrl_bank_select_r;
      ir_cfg_pkg::IDX_XCFG1:    rd_byte = {transceiver_config_one_r[7:3],
        (transceiver_config_one_r[2:0] & transceiver_config_four_r[2:0])
        | (id_f_r & ~transceiver_config_four_r[2:0])};
      ir_cfg_pkg::IDX_RSVD:     rd_byte = 8'h00;
      ir_cfg_pkg::IDX_XCFG3:    rd_byte = transceiver_config_three_r;
      ir_cfg_pkg::IDX_XCFG4:    rd_byte = transceiver_config_four_r;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      if ((ar_addr[ADDR_W-1:5] != '0) || (ar_addr[1:0] != 2'h0)) begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= RESP_SLVERR;
      end else begin
        s_rdata <= {24'h00_0000, rd_byte};
        s_rresp <= RESP_OKAY;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_f_r;
  logic rx_prev_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      {rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r, rx_prev_r} <= 5'h00;
      {id_s1_r, id_s2_r, id_s3_r, id_f_r}            <= 12'h000;
    end else begin
      rx_s1_r   <= rx_subcarrier;
      rx_s2_r   <= rx_s1_r;
      rx_s3_r   <= rx_s2_r;
      rx_prev_r <= rx_f_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_f_r <= rx_s3_r;
      end
      id_s1_r <= xcvr_id_in;
      id_s2_r <= id_s1_r;
      id_s3_r <= id_s2_r;
      // per bit, a change counts only once the two later stages agree
      id_f_r  <= (id_s3_r & ~(id_s2_r ^ id_s3_r)) | (id_f_r & (id_s2_r ^ id_s3_r));
    end
  end

  // ----------------------------------------------------------------
  // transceiver mode-select outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      transceiver_mode_sel_out <= '0;
    end else begin
      transceiver_mode_sel_out.oe <= transceiver_config_four_r[2:0];
      if (transceiver_config_four_r[ir_cfg_pkg::AUTO_CFG_BIT] && mode.uart_mode) begin
        transceiver_mode_sel_out.level <= 3'h0;
      end else begin
        transceiver_mode_sel_out.level <= transceiver_config_one_r[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit modulator
  // ----------------------------------------------------------------
  logic        tx_high;
  logic [15:0] tx_per;
  logic [15:0] tx_wid;
  logic [15:0] tx_cnt_r;

  assign tx_high = remote_ctl_config_r[ir_cfg_pkg::TX_HIGH_BAND_BIT];
  // shared-IR uses a fixed carrier and the high-band width set
  assign tx_per  = mode.sir_mode ? 16'(ir_cfg_pkg::CLK_KHZ / ir_cfg_pkg::SIR_KHZ)
                                 : period_of(tx_carrier_ctrl_r[4:0], tx_high);
  assign tx_wid  = width_of(tx_carrier_ctrl_r[7:5], tx_high || mode.sir_mode);

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_cnt_r   <= 16'h0000;
      tx_carrier <= 1'b0;
    end else begin
      if (!tx_active || tx_cnt_r + 16'h0001 >= tx_per) begin
        tx_cnt_r <= 16'h0000;
      end else begin
        tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
      // reserved codes give no carrier at all
      tx_carrier <= tx_active && (tx_per != 16'h0000) && (tx_cnt_r < tx_wid);
    end
  end

  // ----------------------------------------------------------------
  // receive demodulator window
  // ----------------------------------------------------------------
  logic        rx_high;
  logic        demod_off;
  logic [15:0] rx_ctr;
  logic [17:0] ratio;
  logic [24:0] lo_prod;
  logic [24:0] hi_prod;
  logic [15:0] per_lo;
  logic [15:0] per_hi;
  logic [15:0] rx_cnt_r;
  logic        rise;
  logic        in_win;

  assign rx_high   = remote_ctl_config_r[ir_cfg_pkg::RX_HIGH_BAND_BIT];
  assign demod_off = remote_ctl_config_r[ir_cfg_pkg::DEMOD_DIS_BIT];
  assign rx_ctr    = mode.sir_mode ? 16'(ir_cfg_pkg::CLK_KHZ / ir_cfg_pkg::SIR_KHZ)
                                   : period_of(rx_demod_window_ctrl_r[4:0], rx_high);
  assign ratio     = bw_ratio(rx_demod_window_ctrl_r[7:5]);
  assign lo_prod   = rx_ctr * ratio[17:9];
  assign hi_prod   = rx_ctr * ratio[8:0];
  assign per_lo    = lo_prod[23:8];
  assign per_hi    = hi_prod[23:8];
  assign rise      = rx_f_r && !rx_prev_r;
  assign in_win    = (per_hi != 16'h0000) && (rx_cnt_r >= per_lo) && (rx_cnt_r <= per_hi);

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_cnt_r       <= 16'h0000;
      rx_envelope    <= 1'b0;
      rx_carrier_hit <= 1'b0;
    end else begin
      if (rise) begin
        rx_cnt_r <= 16'h0000;
      end else if (rx_cnt_r != 16'hffff) begin
        rx_cnt_r <= rx_cnt_r + 16'h0001;
      end
      rx_carrier_hit <= !demod_off && rise && in_win;
      if (demod_off) begin
        rx_envelope <= rx_f_r;
      end else if (rise && in_win) begin
        rx_envelope <= 1'b1;
      end else if (rise || rx_cnt_r > per_hi) begin
        rx_envelope <= 1'b0;
      end
    end
  end

endmodule

// ### bench/ir_xcvr_model.sv
// optical transceiver model: received subcarrier bursts and id pin levels
`timescale 1ns/1ns
module ir_xcvr_model #(
  parameter logic [2:0] ID_CODE = 3'h5  // arbitrary id value
) (
  // clock
  input  wire logic       clock,
  // pins toward the block
  output logic            rx_subcarrier,
  output logic [2:0]      id_out
);
  assign id_out = ID_CODE;
  initial rx_subcarrier = 1'b0;
  // line rests low between bursts, so no stale edge reaches the demodulator
  task automatic burst(input int half, input int num);
    for (int i = 0; i < 2 * num; i++) begin
      rx_subcarrier <= ~rx_subcarrier;
      repeat (half) @(posedge clock);
    end
    rx_subcarrier <= 1'b0;
  endtask
endmodule

// ### bench/ir_cfg_sva.sv
// port assertions for the carrier configuration block
`timescale 1ns/1ns
module ir_cfg_sva #(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   srst,
  // register bus
  input wire logic [ADDR_W-1:0]      s_awaddr,
  input wire logic                   s_awvalid,
  input wire logic                   s_awready,
  input wire logic [31:0]            s_wdata,
  input wire logic                   s_wvalid,
  input wire logic                   s_wready,
  input wire logic [1:0]             s_bresp,
  input wire logic                   s_bvalid,
  input wire logic                   s_bready,
  input wire logic                   s_arvalid,
  input wire logic                   s_arready,
  input wire logic [31:0]            s_rdata,
  input wire logic                   s_rvalid,
  input wire logic                   s_rready,
  // mode and pins
  input wire ir_cfg_pkg::link_mode_t mode,
  input wire logic                   tx_active,
  input wire ir_cfg_pkg::xcvr_sel_t  transceiver_mode_sel_out,
  input wire logic                   tx_carrier,
  input wire logic                   rx_carrier_hit
);
  logic [ADDR_W-1:0] aw_q;
  logic [7:0]        w_q;
  logic [7:0]        rc_q;
  logic [7:0]        tx_q;
  logic              auto_q;
  logic [11:0]       hi_cnt;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  always_ff @(posedge clock) begin
    if (s_awvalid && s_awready) aw_q <= s_awaddr;
    if (s_wvalid && s_wready) w_q <= s_wdata[7:0];
  end
  // shadow lags the block by one edge; properties allow for it
  always_ff @(posedge clock) begin
    if (srst) begin
      rc_q   <= 8'h00;
      tx_q   <= 8'h69;
      auto_q <= 1'b0;
    end else if ($rose(s_bvalid) && s_bresp == 2'h0) begin
      if (aw_q == 'h04) tx_q <= w_q;
      if (aw_q == 'h08) rc_q <= w_q;
      if (aw_q == 'h1c) auto_q <= w_q[7];
    end
  end
  always_ff @(posedge clock) hi_cnt <= tx_carrier ? hi_cnt + 12'h001 : 12'h000;

  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd_taken;
    s_arvalid && s_arready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##2 s_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_rd_taken |=> s_rvalid && s_rdata[31:8] == 24'h00_0000)
    else $error("read answer wrong");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data not held");
  a_sel_forced: assert property (auto_q && $past(auto_q) && $past(mode.uart_mode)
    |-> (transceiver_mode_sel_out.level & transceiver_mode_sel_out.oe) == 3'h0)
    else $error("mode select not forced low");
  a_hit_pulse: assert property (rx_carrier_hit |=> !rx_carrier_hit)
    else $error("carrier hit too long");
  a_demod_off: assert property (rc_q[4] && $past(rc_q[4], 8) |-> !rx_carrier_hit)
    else $error("hit while demodulator off");
  a_pulse_width: assert property ($fell(tx_carrier) && tx_active && tx_q[7:5] == 3'h3
    && !rc_q[2] |-> hi_cnt == (mode.sir_mode ? 12'h064 : 12'h36b))
    else $error("carrier pulse width wrong");
endmodule

bind ir_carrier_cfg ir_cfg_sva #(.ADDR_W(ADDR_W)) sva (.clock, .srst, .s_awaddr, .s_awvalid,
  .s_awready, .s_wdata, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid,
  .s_arready, .s_rdata, .s_rvalid, .s_rready, .mode, .tx_active, .transceiver_mode_sel_out,
  .tx_carrier, .rx_carrier_hit);

// ### bench/ir_carrier_cfg_test.sv
// self-checking bench for the carrier configuration block
`timescale 1ns/1ns
module ir_carrier_cfg_test;
  logic                   clock, srst, tx_active, rx_subcarrier, tx_carrier;
  logic                   s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic                   s_arvalid, s_arready, s_rvalid, s_rready, rx_envelope, rx_carrier_hit;
  logic [5:0]             s_awaddr, s_araddr;
  logic [31:0]            s_wdata, s_rdata;
  logic [3:0]             s_wstrb;
  logic [1:0]             s_bresp, s_rresp;
  logic [2:0]             id_pins;
  ir_cfg_pkg::link_mode_t mode;
  ir_cfg_pkg::xcvr_sel_t  sel;
  int                     num_errors, total_checks, hits;

  ir_carrier_cfg DUT (.clock, .srst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mode, .tx_active, .rx_subcarrier,
    .xcvr_id_in(id_pins), .transceiver_mode_sel_out(sel), .tx_carrier, .rx_envelope,
    .rx_carrier_hit);
  ir_xcvr_model xcvr (.clock, .rx_subcarrier, .id_out(id_pins));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (rx_carrier_hit === 1'b1) hits++;

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang(inout int n, input int lim);
    @(posedge clock);
    n++;
    if (n > lim) begin
      num_errors++;
      $display("Error at %0t: wait ran out", $time);
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  task automatic bus(input bit wr, input logic [5:0] a, input logic [7:0] d,
                     input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    if (wr) begin
      s_awaddr  <= a;
      s_awvalid <= 1'b1;
      s_wdata   <= {24'h00_0000, d};
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
    end else begin
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
    end
    do begin
      hang(n, 100);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!(s_bready && s_bvalid) && !(s_rready && s_rvalid));
    check({30'h0, wr ? s_bresp : s_rresp}, {30'h0, er});
    if (!wr) check(s_rdata, exp);
    s_bready <= 1'b0;
    s_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [5:0] adr [5];
    adr = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h18};
    foreach (adr[i]) begin
      bus(1'b1, adr[i], 8'ha5, 32'h0, 2'h0);
      bus(1'b0, adr[i], 8'h00, 32'h0000_00a5, 2'h0);
    end
    bus(1'b1, 6'h14, 8'hff, 32'h0, 2'h0);
    bus(1'b0, 6'h14, 8'h00, 32'h0, 2'h0);
    bus(1'b1, 6'h20, 8'h11, 32'h0, 2'h2);
    bus(1'b0, 6'h20, 8'h00, 32'h0, 2'h2);
    bus(1'b0, 6'h00, 8'h00, 32'h0000_00a5, 2'h0);
    bus(1'b1, 6'h00, 8'h29, 32'h0, 2'h0);
    bus(1'b1, 6'h04, 8'h69, 32'h0, 2'h0);
  endtask
  task automatic t_sel(input logic [7:0] auto_oe, input logic uart, input logic [5:0] exp);
    bus(1'b1, 6'h1c, auto_oe, 32'h0, 2'h0);
    bus(1'b1, 6'h10, 8'h07, 32'h0, 2'h0);
    mode <= {uart, 1'b0};
    repeat (3) @(posedge clock);
    check({26'h0, sel}, {26'h0, exp});
    mode <= 2'b00;
  endtask
  task automatic t_rx(input logic sir, input logic [7:0] rc, input logic [7:0] dc,
                      input int half, input int num, input logic hit);
    bus(1'b1, 6'h08, rc, 32'h0, 2'h0);
    bus(1'b1, 6'h00, dc, 32'h0, 2'h0);
    mode <= {1'b0, sir};
    // idle past every window used, so a burst's first edge never pairs with the last one
    repeat (4000) @(posedge clock);
    hits = 0;
    xcvr.burst(half, num);
    repeat (8) @(posedge clock);
    check({31'h0, hits > 0}, {31'h0, hit});
    check({31'h0, rx_envelope}, {31'h0, hit});
  endtask
  task automatic t_tx(input logic sir, input logic [7:0] rc, input logic [7:0] tc, input int exp);
    int n;
    int t0;
    n = 0;
    bus(1'b1, 6'h08, rc, 32'h0, 2'h0);
    bus(1'b1, 6'h04, tc, 32'h0, 2'h0);
    mode <= {1'b0, sir};
    tx_active <= 1'b1;
    while (tx_carrier !== 1'b0) hang(n, 20000);
    while (tx_carrier !== 1'b1) hang(n, 20000);
    t0 = n;
    while (tx_carrier !== 1'b0) hang(n, 20000);
    while (tx_carrier !== 1'b1) hang(n, 20000);
    check({31'h0, (n - t0 - exp) inside {[-1:1]}}, 32'h0000_0001);
    tx_active <= 1'b0;
  endtask

  initial begin
    {srst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, tx_active} = 7'h40;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    mode = 2'b00;
    num_errors = 0;
    total_checks = 0;
    hits = 0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, 6'h00, 8'h00, 32'h0000_0029, 2'h0);
    bus(1'b0, 6'h04, 8'h00, 32'h0000_0069, 2'h0);
    bus(1'b0, 6'h10, 8'h00, 32'h0000_0005, 2'h0);
    bus(1'b0, 6'h1c, 8'h00, 32'h0000_0000, 2'h0);
    t_regs();
    t_sel(8'h87, 1'b1, 6'h07);
    t_sel(8'h87, 1'b0, 6'h3f);
    t_sel(8'h07, 1'b1, 6'h3f);
    bus(1'b1, 6'h1c, 8'h00, 32'h0, 2'h0);
    t_rx(1'b0, 8'h00, 8'h29, 1736, 2, 1'b1);
    t_rx(1'b0, 8'h00, 8'h29, 2083, 2, 1'b0);
    t_rx(1'b0, 8'h10, 8'h29, 1736, 2, 1'b0);
    t_rx(1'b1, 8'h00, 8'h29, 125, 8, 1'b1);
    t_rx(1'b1, 8'h00, 8'h29, 156, 8, 1'b0);
    t_rx(1'b1, 8'h00, 8'hdf, 156, 8, 1'b1);
    t_rx(1'b0, 8'h20, 8'h28, 137, 8, 1'b1);
    t_rx(1'b0, 8'h20, 8'h23, 137, 8, 1'b0);
    t_tx(1'b1, 8'h00, 8'h69, 250);
    t_tx(1'b1, 8'h00, 8'h7f, 250);
    t_tx(1'b0, 8'h00, 8'h69, 3472);
    t_tx(1'b0, 8'h00, 8'h7d, 2232);
    t_tx(1'b0, 8'h04, 8'h68, 277);
    stop_test();
  end
endmodule
